// *** sie_map.vh ***
`ifndef SIE_MAP_VH
`define SIE_MAP_VH

// timing
`define SIE_CLK_KHZ         250000
`define SIE_BLINK_HALF_MS   500
`define SIE_BLINK_HALF_CYC  (`SIE_BLINK_HALF_MS * `SIE_CLK_KHZ)

// register offsets (byte addresses)
`define SIE_OFS_CTRL        8'h00
`define SIE_OFS_STATUS      8'h04
`define SIE_OFS_MASK        8'h08
`define SIE_OFS_DISPLAY     8'h0c
`define SIE_OFS_CHAN        8'h10

// reset values
`define SIE_CTRL_RST        32'h00000001
`define SIE_MASK_RST        6'h00

// control fields
`define SIE_CTRL_ENABLE     0
`define SIE_CTRL_FREEZE     1

// event bits of status and mask
`define SIE_EV_W            6
`define SIE_EV_CRIT         0
`define SIE_EV_ABORT        1
`define SIE_EV_NETFAIL      2
`define SIE_EV_CONNERR      3
`define SIE_EV_CHANERR      4
`define SIE_EV_SUPPLY       5

// module state codes
`define SIE_MOD_SELFTEST    3'h0
`define SIE_MOD_CONFIG      3'h1
`define SIE_MOD_WAIT_ID     3'h2
`define SIE_MOD_IDLE        3'h3
`define SIE_MOD_EXEC        3'h4
`define SIE_MOD_ABORT       3'h5
`define SIE_MOD_CRIT        3'h6

// display codes for two-colour indicators
`define SIE_DSP_OFF         3'h0
`define SIE_DSP_GREEN       3'h1
`define SIE_DSP_GREEN_BLINK 3'h2
`define SIE_DSP_RED_BLINK   3'h3
`define SIE_DSP_RED         3'h4
`define SIE_DSP_ALT         3'h5

// display codes for supply and config lock
`define SIE_SUP_OFF         2'h0
`define SIE_SUP_RED         2'h1
`define SIE_SUP_GREEN       2'h2
`define SIE_LOCK_OFF        2'h0
`define SIE_LOCK_STEADY     2'h1
`define SIE_LOCK_BLINK      2'h2

`endif

// *** sie_status_indicator_encoder.v ***
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sie_map.vh"

module sie_status_indicator_encoder #(
    parameter NCH         = 12,
    parameter HALF_CYCLES = `SIE_BLINK_HALF_CYC,
    parameter AW          = 8
) (
    input  wire            i_ref_clk,
    input  wire            i_sys_rst,
    // ahb-lite slave
    input  wire            i_hsel,
    input  wire [AW-1:0]   i_haddr,
    input  wire [1:0]      i_htrans,
    input  wire            i_hwrite,
    input  wire [2:0]      i_hsize,
    input  wire            i_hready,
    input  wire [31:0]     i_hwdata,
    output reg  [31:0]     o_hrdata,
    output reg             o_hreadyout,
    output reg             o_hresp,
    output reg             o_irq,
    // node state
    input  wire            i_switched_output_supply_present,
    input  wire            i_switched_output_supply_in_range,
    input  wire            i_logic_supply_present,
    input  wire            i_logic_supply_in_range,
    input  wire            i_cfg_valid,
    input  wire            i_cfg_locked,
    input  wire [2:0]      i_module_state,
    input  wire            i_unrecoverable_fault,
    input  wire            i_net_online,
    input  wire            i_net_conn_established,
    input  wire            i_net_conn_error,
    input  wire            i_net_bus_off,
    input  wire            i_net_dup_address,
    input  wire            i_net_wait_id,
    input  wire [NCH-1:0]  i_chan_active,
    input  wire [NCH-1:0]  i_chan_error,
    // indicators
    output reg             o_switched_output_supply_red,
    output reg             o_switched_output_supply_green,
    output reg             o_logic_supply_red,
    output reg             o_logic_supply_green,
    output reg             o_config_lock_indicator_yellow,
    output reg             o_module_state_indicator_red,
    output reg             o_module_state_indicator_green,
    output reg             o_network_state_indicator_red,
    output reg             o_network_state_indicator_green,
    output reg  [NCH-1:0]  o_chan_red,
    output reg  [NCH-1:0]  o_chan_yellow
);

    localparam CW = $clog2(HALF_CYCLES + 1);
    localparam [31:0]   HALF_LAST_W = HALF_CYCLES - 1;
    localparam [CW-1:0] HALF_LAST   = HALF_LAST_W[CW-1:0];
    localparam [CW-1:0] CNT_ONE     = {{(CW-1){1'b0}}, 1'b1};

    //------------------------------------------------------------
    // blink timebase
    //------------------------------------------------------------
    reg  [CW-1:0]  blink_cnt_reg;
    reg            blink_phase_reg;
    reg  [31:0]    ctrl_reg;
    wire           ctl_enable = ctrl_reg[`SIE_CTRL_ENABLE];
    wire           ctl_freeze = ctrl_reg[`SIE_CTRL_FREEZE];

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            blink_cnt_reg   <= {CW{1'b0}};
            blink_phase_reg <= 1'b0;
        end else if (ctl_freeze) begin
            // hold phase for lamp inspection
            blink_cnt_reg   <= {CW{1'b0}};
        end else if (blink_cnt_reg == HALF_LAST) begin
            blink_cnt_reg   <= {CW{1'b0}};
            blink_phase_reg <= ~blink_phase_reg;
        end else begin
            blink_cnt_reg   <= blink_cnt_reg + CNT_ONE;
        end
    end

    //------------------------------------------------------------
    // display code selection
    //------------------------------------------------------------
    reg  [1:0]  sw_sup_code;
    reg  [1:0]  lg_sup_code;
    reg  [1:0]  lock_code;
    reg  [2:0]  mod_code;
    reg  [2:0]  net_code;

    always @* begin
        if (!i_switched_output_supply_present)
            sw_sup_code = `SIE_SUP_OFF;
        else if (!i_switched_output_supply_in_range)
            sw_sup_code = `SIE_SUP_RED;
        else
            sw_sup_code = `SIE_SUP_GREEN;
        if (!i_logic_supply_present)
            lg_sup_code = `SIE_SUP_OFF;
        else if (!i_logic_supply_in_range)
            lg_sup_code = `SIE_SUP_RED;
        else
            lg_sup_code = `SIE_SUP_GREEN;
        if (!i_cfg_valid)
            lock_code = `SIE_LOCK_OFF;
        else if (i_cfg_locked)
            lock_code = `SIE_LOCK_STEADY;
        else
            lock_code = `SIE_LOCK_BLINK;
    end

    always @* begin
        if (i_unrecoverable_fault) begin
            mod_code = `SIE_DSP_RED;
        end else begin
            case (i_module_state)
                `SIE_MOD_EXEC:     mod_code = `SIE_DSP_GREEN;
                `SIE_MOD_IDLE:     mod_code = `SIE_DSP_GREEN_BLINK;
                `SIE_MOD_ABORT:    mod_code = `SIE_DSP_RED_BLINK;
                `SIE_MOD_CRIT:     mod_code = `SIE_DSP_RED;
                `SIE_MOD_SELFTEST: mod_code = `SIE_DSP_ALT;
                `SIE_MOD_CONFIG:   mod_code = `SIE_DSP_ALT;
                `SIE_MOD_WAIT_ID:  mod_code = `SIE_DSP_ALT;
                default:           mod_code = `SIE_DSP_OFF;
            endcase
        end
    end

    // severity order: comm failure, not on-line, connection error, waiting, ok
    always @* begin
        if (i_net_bus_off || i_net_dup_address)
            net_code = `SIE_DSP_RED;
        else if (!i_net_online)
            net_code = `SIE_DSP_OFF;
        else if (i_net_conn_error)
            net_code = `SIE_DSP_RED_BLINK;
        else if (i_net_wait_id)
            net_code = `SIE_DSP_ALT;
        else if (i_net_conn_established)
            net_code = `SIE_DSP_GREEN;
        else
            net_code = `SIE_DSP_GREEN_BLINK;
    end

    function [1:0] dsp_rg;
        input [2:0] code;
        input       phase;
        begin
            case (code)
                `SIE_DSP_GREEN:       dsp_rg = 2'h1;
                `SIE_DSP_GREEN_BLINK: dsp_rg = {1'b0, phase};
                `SIE_DSP_RED_BLINK:   dsp_rg = {phase, 1'b0};
                `SIE_DSP_RED:         dsp_rg = 2'h2;
                `SIE_DSP_ALT:         dsp_rg = {phase, ~phase};
                default:              dsp_rg = 2'h0;
            endcase
        end
    endfunction

    wire [1:0] mod_rg = dsp_rg(mod_code, blink_phase_reg);
    wire [1:0] net_rg = dsp_rg(net_code, blink_phase_reg);

    //------------------------------------------------------------
    // indicator outputs
    //------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (i_sys_rst || !ctl_enable) begin
            o_switched_output_supply_red    <= 1'b0;
            o_switched_output_supply_green  <= 1'b0;
            o_logic_supply_red              <= 1'b0;
            o_logic_supply_green            <= 1'b0;
            o_config_lock_indicator_yellow  <= 1'b0;
            o_module_state_indicator_red    <= 1'b0;
            o_module_state_indicator_green  <= 1'b0;
            o_network_state_indicator_red   <= 1'b0;
            o_network_state_indicator_green <= 1'b0;
            o_chan_red                      <= {NCH{1'b0}};
            o_chan_yellow                   <= {NCH{1'b0}};
        end else begin
            o_switched_output_supply_red    <= (sw_sup_code == `SIE_SUP_RED);
            o_switched_output_supply_green  <= (sw_sup_code == `SIE_SUP_GREEN);
            o_logic_supply_red              <= (lg_sup_code == `SIE_SUP_RED);
            o_logic_supply_green            <= (lg_sup_code == `SIE_SUP_GREEN);
            o_config_lock_indicator_yellow  <= (lock_code == `SIE_LOCK_STEADY) ||
                ((lock_code == `SIE_LOCK_BLINK) && blink_phase_reg);
            o_module_state_indicator_red    <= mod_rg[1];
            o_module_state_indicator_green  <= mod_rg[0];
            o_network_state_indicator_red   <= net_rg[1];
            o_network_state_indicator_green <= net_rg[0];
            o_chan_red                      <= i_chan_error;
            o_chan_yellow                   <= i_chan_active & ~i_chan_error;
        end
    end

    //------------------------------------------------------------
    // events
    //------------------------------------------------------------
    reg  [`SIE_EV_W-1:0] cond_prev_reg;
    reg  [`SIE_EV_W-1:0] status_reg;
    reg  [`SIE_EV_W-1:0] mask_reg;
    reg  [`SIE_EV_W-1:0] cond_now;

    always @* begin
        cond_now = {`SIE_EV_W{1'b0}};
        cond_now[`SIE_EV_CRIT]    = (mod_code == `SIE_DSP_RED);
        cond_now[`SIE_EV_ABORT]   = (mod_code == `SIE_DSP_RED_BLINK);
        cond_now[`SIE_EV_NETFAIL] = (net_code == `SIE_DSP_RED);
        cond_now[`SIE_EV_CONNERR] = (net_code == `SIE_DSP_RED_BLINK);
        cond_now[`SIE_EV_CHANERR] = |i_chan_error;
        cond_now[`SIE_EV_SUPPLY]  = (sw_sup_code == `SIE_SUP_RED) ||
                                    (lg_sup_code == `SIE_SUP_RED);
    end

    wire [`SIE_EV_W-1:0] ev_rise = cond_now & ~cond_prev_reg;

    //------------------------------------------------------------
    // ahb-lite slave
    //------------------------------------------------------------
    reg            wr_pend_reg;
    reg  [AW-1:0]  wr_addr_reg;
    reg  [31:0]    rd_mux;
    wire           addr_ok = i_hsel && i_hready && i_htrans[1];
    wire           wr_ctrl = wr_pend_reg && (wr_addr_reg == `SIE_OFS_CTRL);
    wire           wr_stat = wr_pend_reg && (wr_addr_reg == `SIE_OFS_STATUS);
    wire           wr_mask = wr_pend_reg && (wr_addr_reg == `SIE_OFS_MASK);
    wire [`SIE_EV_W-1:0] w1c = wr_stat ? i_hwdata[`SIE_EV_W-1:0]
                                       : {`SIE_EV_W{1'b0}};

    always @* begin
        rd_mux = 32'h00000000;
        case (i_haddr)
            `SIE_OFS_CTRL:    rd_mux = {30'h00000000, ctrl_reg[1:0]};
            `SIE_OFS_STATUS:  rd_mux[`SIE_EV_W-1:0] = status_reg;
            `SIE_OFS_MASK:    rd_mux[`SIE_EV_W-1:0] = mask_reg;
            `SIE_OFS_DISPLAY: rd_mux = {10'h000, lg_sup_code, 2'h0, sw_sup_code,
                                        2'h0, lock_code, 1'b0, net_code,
                                        1'b0, mod_code, 3'h0, blink_phase_reg};
            `SIE_OFS_CHAN:    rd_mux = {{(16-NCH){1'b0}}, i_chan_error,
                                        {(16-NCH){1'b0}}, i_chan_active};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= {AW{1'b0}};
            o_hrdata      <= 32'h00000000;
            o_hreadyout   <= 1'b1;
            o_hresp       <= 1'b0;
            ctrl_reg      <= `SIE_CTRL_RST;
            mask_reg      <= `SIE_MASK_RST;
            status_reg    <= {`SIE_EV_W{1'b0}};
            cond_prev_reg <= {`SIE_EV_W{1'b0}};
            o_irq         <= 1'b0;
        end else begin
            wr_pend_reg   <= addr_ok && i_hwrite;
            wr_addr_reg   <= i_haddr;
            o_hreadyout   <= 1'b1;
            o_hresp       <= 1'b0;
            if (addr_ok && !i_hwrite)
                o_hrdata  <= rd_mux;
            if (wr_ctrl)
                ctrl_reg  <= {30'h00000000, i_hwdata[1:0]};
            if (wr_mask)
                mask_reg  <= i_hwdata[`SIE_EV_W-1:0];
            cond_prev_reg <= cond_now;
            // a new event outranks a same-cycle clear
            status_reg    <= (status_reg & ~w1c) | ev_rise;
            o_irq         <= |(status_reg & mask_reg);
        end
    end

endmodule // sie_status_indicator_encoder
`default_nettype wire

// *** sie_indicator_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sie_map.vh"
// ----------------------
// indicator checks
// ----------------------
module sie_indicator_sva #(
    parameter NCH         = 12,
    parameter HALF_CYCLES = `SIE_BLINK_HALF_CYC
) (
    input wire logic           i_ref_clk,
    input wire logic           i_sys_rst,
    input wire logic [2:0]     i_module_state,
    input wire logic           i_unrecoverable_fault,
    input wire logic           i_net_online,
    input wire logic           i_net_bus_off,
    input wire logic           i_net_dup_address,
    input wire logic [NCH-1:0] i_chan_active,
    input wire logic [NCH-1:0] i_chan_error,
    input wire logic           o_module_state_indicator_red,
    input wire logic           o_module_state_indicator_green,
    input wire logic           o_network_state_indicator_red,
    input wire logic           o_network_state_indicator_green,
    input wire logic [NCH-1:0] o_chan_red,
    input wire logic [NCH-1:0] o_chan_yellow
);
    wire mr   = o_module_state_indicator_red;
    wire mg   = o_module_state_indicator_green;
    wire nr   = o_network_state_indicator_red;
    wire ng   = o_network_state_indicator_green;
    wire ok   = !i_unrecoverable_fault;
    wire idle = ok && i_module_state == `SIE_MOD_IDLE;
    wire dead = i_net_bus_off || i_net_dup_address;
    // ----------------------
    // run-length counters
    // ----------------------
    logic        rst_q;
    logic [31:0] idle_run;
    logic [31:0] hi_run;
    logic [31:0] lo_run;
    always @(posedge i_ref_clk) begin
        rst_q    <= i_sys_rst;
        idle_run <= (i_sys_rst || !idle) ? 32'h0 : idle_run + 32'h1;
        hi_run   <= (i_sys_rst || !mg) ? 32'h0 : hi_run + 32'h1;
        lo_run   <= (i_sys_rst || mg) ? 32'h0 : lo_run + 32'h1;
    end
    default clocking @(posedge i_ref_clk); endclocking
    // outputs lag inputs by one edge, so the release edge is skipped as well
    default disable iff (i_sys_rst || rst_q);
    a_mod_exec: assert property (ok && i_module_state == `SIE_MOD_EXEC |=> mg && !mr)
        else $error("module indicator not steady green");
    a_mod_abort: assert property (ok && i_module_state == `SIE_MOD_ABORT |=> !mg)
        else $error("module indicator green in abort");
    a_mod_crit: assert property (!ok || i_module_state == `SIE_MOD_CRIT
        |=> mr && !mg) else $error("module indicator not steady red");
    a_mod_alt: assert property (ok && i_module_state < `SIE_MOD_IDLE |=> mr != mg)
        else $error("module indicator not alternating");
    // a run is judged only when idle covered it and the edge before it
    a_mod_blink_high: assert property ($fell(mg) && idle_run >= HALF_CYCLES + 2
        |-> hi_run == HALF_CYCLES) else $error("idle blink lit half wrong");
    a_mod_blink_low: assert property ($rose(mg) && idle_run >= HALF_CYCLES + 2
        |-> lo_run == HALF_CYCLES) else $error("idle blink dark half wrong");
    a_net_dark: assert property (!i_net_online && !dead |=> !nr && !ng)
        else $error("network indicator lit while off-line");
    a_net_fail: assert property (dead |=> nr && !ng)
        else $error("network indicator not steady red");
    a_chan_map: assert property (1'b1 |=> o_chan_red == $past(i_chan_error)
        && o_chan_yellow == $past(i_chan_active & ~i_chan_error))
        else $error("channel indicators wrong");
endmodule // sie_indicator_sva
`default_nettype wire

// *** sie_led_watch.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------
// operator view: lit cycles per led
// ----------------------
module sie_led_watch #(
    parameter W = 9
) (
    input  wire logic           i_clk,
    input  wire logic           i_clear,
    input  wire logic [W-1:0]   i_led,
    output var  logic [6*W-1:0] o_on_cnt
);
    always @(posedge i_clk) begin
        for (int i = 0; i < W; i++) begin
            o_on_cnt[i*6+:6] <= i_clear ? 6'h00 : o_on_cnt[i*6+:6] + 6'(i_led[i]);
        end
    end
endmodule // sie_led_watch
`default_nettype wire

// *** sie_status_indicator_encoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sie_map.vh"
module sie_status_indicator_encoder_tb;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, clr = 1'b0;
    logic [7:0]  i_haddr = 8'h00;
    logic [1:0]  i_htrans = 2'b00;
    logic [2:0]  i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0, rd;
    logic        ph;
    logic [15:0] st = 16'h0;
    logic [11:0] chan_act = 12'h0, chan_err = 12'h0;
    logic [51:0] rows [8];
    wire  [31:0] o_hrdata;
    wire         o_hreadyout, o_hresp, o_irq;
    wire  [8:0]  led;
    wire  [11:0] chan_red, chan_yel;
    wire  [53:0] cnt;
    int          err_count = 0, cmp_count = 0;
    always #2 i_ref_clk = ~i_ref_clk;
    sie_status_indicator_encoder #(.HALF_CYCLES(8)) dut (
        .i_ref_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
        .i_hready(o_hreadyout), .i_hwdata, .o_hrdata, .o_hreadyout, .o_hresp, .o_irq,
        .i_switched_output_supply_present(st[15]), .i_switched_output_supply_in_range(st[14]),
        .i_logic_supply_present(st[13]), .i_logic_supply_in_range(st[12]),
        .i_cfg_valid(st[11]), .i_cfg_locked(st[10]), .i_module_state(st[9:7]),
        .i_unrecoverable_fault(st[6]), .i_net_online(st[5]), .i_net_conn_established(st[4]),
        .i_net_conn_error(st[3]), .i_net_bus_off(st[2]), .i_net_dup_address(st[1]),
        .i_net_wait_id(st[0]), .i_chan_active(chan_act), .i_chan_error(chan_err),
        .o_switched_output_supply_red(led[8]), .o_switched_output_supply_green(led[7]),
        .o_logic_supply_red(led[6]), .o_logic_supply_green(led[5]),
        .o_config_lock_indicator_yellow(led[4]), .o_module_state_indicator_red(led[3]),
        .o_module_state_indicator_green(led[2]), .o_network_state_indicator_red(led[1]),
        .o_network_state_indicator_green(led[0]), .o_chan_red(chan_red), .o_chan_yellow(chan_yel)
    );
    sie_led_watch u_watch (.i_clk(i_ref_clk), .i_clear(clr), .i_led(led), .o_on_cnt(cnt));
    task chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // hsel stays high between transfers; idle htrans ends each one
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_hsel <= 1'b1;
        i_haddr <= a;
        i_htrans <= 2'b10;
        i_hwrite <= w;
        do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'b00;
        i_hwdata <= d;
        do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
        chk(36'(o_hresp), 36'h0);
    endtask
    task automatic irq_after(input logic [7:0] a, input logic [31:0] d, input logic e);
        bus(1'b1, a, d);
        repeat (2) @(posedge i_ref_clk);
        chk(36'(o_irq), 36'(e));
    endtask
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------
    // stimulus
    // ----------------------
    initial begin
        // led codes per nibble: 0 dark, 1 half lit, 2 steady
        rows[0] = {16'b11_11_11_100_0_110000, 36'h020220202};
        rows[1] = {16'b00_10_10_011_0_100000, 36'h002010101};
        rows[2] = {16'b10_00_01_101_0_111000, 36'h200001010};
        rows[3] = {16'b11_11_00_110_0_100100, 36'h020202020};
        rows[4] = {16'b11_11_00_100_1_000010, 36'h020202020};
        rows[5] = {16'b11_11_11_000_0_000000, 36'h020221100};
        rows[6] = {16'b11_11_11_001_0_100001, 36'h020221111};
        rows[7] = {16'b11_11_11_010_0_110001, 36'h020221111};
        repeat (6) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            st <= rows[k][51:36];
            repeat (2) @(posedge i_ref_clk);
            clr <= 1'b1;
            @(posedge i_ref_clk);
            clr <= 1'b0;
            repeat (33) @(posedge i_ref_clk);
            for (int i = 0; i < 9; i++) begin
                chk(36'(cnt[i*6+:6]), 36'({rows[k][i*4+:4], 4'h0}));
            end
        end
        chan_act <= 12'hf0f;
        chan_err <= 12'h0ff;
        repeat (2) @(posedge i_ref_clk);
        chk(36'(chan_red), 36'h0ff);
        chk(36'(chan_yel), 36'hf00);
        chk(36'(o_irq), 36'h0);
        bus(1'b0, `SIE_OFS_STATUS, 32'h0);
        chk(36'(rd), 36'h3f);
        irq_after(`SIE_OFS_MASK, 32'h1, 1'b1);
        irq_after(`SIE_OFS_STATUS, 32'h1, 1'b0);
        irq_after(`SIE_OFS_MASK, 32'h2, 1'b1);
        bus(1'b0, `SIE_OFS_STATUS, 32'h0);
        chk(36'(rd), 36'h3e);
        bus(1'b0, `SIE_OFS_CTRL, 32'h0);
        chk(36'(rd), 36'(`SIE_CTRL_RST));
        bus(1'b0, 8'h20, 32'h0);
        chk(36'(rd), 36'h0);
        bus(1'b0, `SIE_OFS_DISPLAY, 32'h0);
        chk(36'(rd & 32'hfffffffe), 36'h221550);
        bus(1'b0, `SIE_OFS_CHAN, 32'h0);
        chk(36'(rd), 36'hff0f0f);
        // disabled leds go dark; freeze holds the blink phase
        st <= 16'b11_11_11_111_0_000000;
        chan_act <= 12'h000;
        chan_err <= 12'h000;
        bus(1'b1, `SIE_OFS_CTRL, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        chk(36'({led, chan_red, chan_yel}), 36'h0);
        bus(1'b1, `SIE_OFS_CTRL, 32'h3);
        repeat (2) @(posedge i_ref_clk);
        chk(36'(led), 36'h0b0);
        bus(1'b0, `SIE_OFS_DISPLAY, 32'h0);
        ph = rd[0];
        // next read address lands one half period later
        repeat (6) @(posedge i_ref_clk);
        bus(1'b0, `SIE_OFS_DISPLAY, 32'h0);
        chk(36'(rd[0]), 36'(ph));
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        chk(36'({led, chan_red, chan_yel, o_irq}), 36'h0);
        chk(36'({o_hreadyout, o_hrdata}), 36'h100000000);
        i_sys_rst <= 1'b0;
        @(posedge i_ref_clk);
        bus(1'b0, `SIE_OFS_MASK, 32'h0);
        chk(36'(rd), 36'h0);
        report_and_stop();
    end
    initial begin
        #20000;
        err_count++;
        report_and_stop();
    end
endmodule // sie_status_indicator_encoder_tb
bind sie_status_indicator_encoder sie_indicator_sva #(.NCH(NCH), .HALF_CYCLES(HALF_CYCLES)) u_sva (
    .i_ref_clk, .i_sys_rst, .i_module_state, .i_unrecoverable_fault, .i_net_online,
    .i_net_bus_off, .i_net_dup_address, .i_chan_active, .i_chan_error, .o_chan_red,
    .o_chan_yellow, .o_module_state_indicator_red, .o_module_state_indicator_green,
    .o_network_state_indicator_red, .o_network_state_indicator_green);
`default_nettype wire
